// File: logic/gpio_irq_map.vh
// Purpose: Register offsets, fields and reset values for the pin-function block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef GPIO_IRQ_MAP_VH
`define GPIO_IRQ_MAP_VH

`define OFF_IRQ_ENABLE   12'h000   // Core interrupt-enable register
`define OFF_IRQ_POLARITY 12'h004   // External interrupt polarity register
`define OFF_GP_DIR       12'h008   // Direction of general-purpose pins 9..15 and 4..7
`define OFF_GP_OUT       12'h00C   // Output data of general-purpose pins
`define OFF_GP_IN        12'h010   // Pin input levels, read only
`define OFF_IRQ_STATUS   12'h014   // Sticky event status, clear on read
`define OFF_IRQ_MASK     12'h018   // Interrupt mask, same layout as status
`define OFF_PCI_CTRL     12'h01C   // PCI side outputs and strap readback

`define IER_EXT_LSB      4         // External enables sit in bits 7:4
`define IER_EXT_MSB      7
`define ST_NMI_BIT       4         // Status: bits 3:0 external, bit 4 nmi
`define ST_WIDTH         5
`define PCI_STRAP_BIT    4         // PCI control readback of strap

`define RST_ZERO32       32'h0000_0000

`endif

// File: logic/edge_sync.v
// Purpose: Two-flop synchroniser with selectable edge pulse
// Assumes: One clock, asynchronous active-low reset
// Notes:   First flop feeds only the second flop
`timescale 1ns/1ns
module edge_sync (
	input  wire i_ref_clk,   // Device clock
	input  wire i_rst_n,     // Asynchronous reset, active low
	input  wire i_pin,       // Raw pin level
	input  wire i_rise,      // 1 selects rising edge, 0 falling
	output wire o_level,     // Synchronised level
	output wire o_pulse      // One-cycle edge pulse
);
	reg meta;                // First stage, read only by sync
	reg sync;                // Second stage
	reg prev;                // Delayed copy for edge detect

	// Synchroniser and history
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= i_pin; // R9
			sync <= meta;
			prev <= sync;
		end
	end

	assign o_level = sync;
	// Edge only on a change, so steady levels never pulse
	assign o_pulse = i_rise ? (sync & ~prev) : (~sync & prev); // R9
endmodule // edge_sync

// File: logic/gpio_ext_interrupt_pins.v
// Purpose: General-purpose pins, external interrupts, nmi and PCI pin muxing
// Assumes: APB slave, inputs synchronous to i_ref_clk (interrupt and nmi pins still resynchronised)
// Notes:   PCI strap caught on the first clock after reset release
//
// Function
// R1: Rising edge on nmi input raises request
// R2: After reset shared pins are inputs only
// R3: Enable bits 7:4 select interrupt use
// R4: Interrupt pins detect edges, not levels
// R5: Polarity bits 3:0 pick each edge
// R6: Pins 9..15 idle after reset
// R7: PCI mode fixes pin directions per signal
// R8: Strap at reset selects PCI or general use
// R9: Synchronise pins before edge detection
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "gpio_irq_map.vh"
module gpio_ext_interrupt_pins #(
	parameter NUM_EXT = 4      // Shared interrupt pins
) (
	input  wire        i_ref_clk,         // Device clock, 10 MHz
	input  wire        i_rst_n,           // Asynchronous reset, active low
	input  wire        i_psel,            // APB select
	input  wire        i_penable,         // APB access phase
	input  wire        i_pwrite,          // APB write
	input  wire [11:0] i_paddr,           // APB byte address
	input  wire [31:0] i_pwdata,          // APB write data
	output reg  [31:0] o_prdata,          // APB read data
	output reg         o_pready,          // APB ready
	output reg         o_pslverr,         // APB error on unmapped address
	input  wire        i_nmi,             // Non-maskable interrupt pin
	input  wire [3:0]  i_ext_pin,         // Pins 7..4 input level
	output reg  [3:0]  o_ext_pin,         // Pins 7..4 output level
	output reg  [3:0]  o_ext_pin_oe,      // Pins 7..4 output enable
	input  wire [6:0]  i_gp_hi,           // Pins 15..9 input level
	output reg  [6:0]  o_gp_hi,           // Pins 15..9 output level
	output reg  [6:0]  o_gp_hi_oe,        // Pins 15..9 output enable
	input  wire        i_pci_en_strap,    // PCI enable strap
	output reg         o_pci_mode,        // PCI function selected
	output reg  [3:0]  o_ext_irq,         // Edge request pulses to core
	output reg         o_nmi_req,         // Nmi request pulse to core
	output reg         o_irq              // Level interrupt, unmasked status
);
	// Pin indices of pins 15..9 within the 7-bit group
	localparam IDX_PCI_RESET = 6;   // pci_reset_in, input
	localparam IDX_PCI_CLK   = 5;   // PCI clock, input
	localparam IDX_PCI_IRQA  = 4;   // pci_irq_a_out, three-state out
	localparam IDX_PCI_GRANT = 3;   // pci_grant_in, input
	localparam IDX_PCI_REQ   = 2;   // pci_request_out, three-state out
	localparam IDX_PCI_BE3   = 1;   // pci_byte_enable_3, bidirectional
	localparam IDX_PCI_IDSEL = 0;   // pci_init_select_in, input

	// Software registers
	reg [31:0] core_irq_enable_reg;   // Bits 7:4 select interrupt use
	reg [3:0]  ext_irq_polarity_reg;  // 1 rising, 0 falling
	reg [10:0] gp_dir;                // [10:4] pins 15..9, [3:0] pins 7..4
	reg [10:0] gp_out;                // Output data, same layout
	reg [4:0]  pci_ctrl;              // [0] irq-a, [1] request, [2] be3 drive, [3] be3 value
	reg [`ST_WIDTH-1:0] irq_status;   // Sticky events
	reg [`ST_WIDTH-1:0] irq_mask;     // 1 passes the event
	reg        strap_taken;           // Strap already caught
	reg [`ST_WIDTH-1:0] next_status;  // Status after events and clear

	wire [3:0] ext_level;             // Synchronised pin levels
	wire [3:0] ext_edge;              // Qualified edge pulses
	wire       nmi_edge;              // Rising edge of nmi
	wire       wr_en;                 // Write access phase
	wire       rd_en;                 // Read access phase

	assign wr_en = i_psel & i_penable & i_pwrite;
	assign rd_en = i_psel & i_penable & ~i_pwrite;

	// Address decode, used for reads and writes
	function mapped;
		input [11:0] a;
		begin
			if (a == `OFF_IRQ_ENABLE) mapped = 1'b1;
			else if (a == `OFF_IRQ_POLARITY) mapped = 1'b1;
			else if (a == `OFF_GP_DIR) mapped = 1'b1;
			else if (a == `OFF_GP_OUT) mapped = 1'b1;
			else if (a == `OFF_GP_IN) mapped = 1'b1;
			else if (a == `OFF_IRQ_STATUS) mapped = 1'b1;
			else if (a == `OFF_IRQ_MASK) mapped = 1'b1;
			else if (a == `OFF_PCI_CTRL) mapped = 1'b1;
			else mapped = 1'b0;
		end
	endfunction

	// One synchroniser per interrupt pin
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g = g + 1) begin : gen_ext
			edge_sync u_sync (
				.i_ref_clk (i_ref_clk),
				.i_rst_n   (i_rst_n),
				.i_pin     (i_ext_pin[g]),
				.i_rise    (ext_irq_polarity_reg[g]), // R5
				.o_level   (ext_level[g]),
				.o_pulse   (ext_edge[g])              // R4
			);
		end
	endgenerate

	// Nmi always on the rising edge
	edge_sync u_nmi (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_nmi),
		.i_rise    (1'b1),       // R1
		.o_level   (),
		.o_pulse   (nmi_edge)
	);

	// Strap caught once after reset release; reset value is a constant
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strap_taken <= 1'b0;
			o_pci_mode  <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			o_pci_mode  <= i_pci_en_strap; // R8
		end
	end

	// Status next value: set wins over read clear
	always @* begin
		next_status = irq_status;
		if (rd_en && i_paddr == `OFF_IRQ_STATUS) begin
			next_status = {`ST_WIDTH{1'b0}};
		end
		next_status[3:0] = next_status[3:0] | (ext_edge & core_irq_enable_reg[`IER_EXT_MSB:`IER_EXT_LSB]);
		next_status[`ST_NMI_BIT] = next_status[`ST_NMI_BIT] | nmi_edge;
	end

	// Register writes and status update
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			core_irq_enable_reg  <= `RST_ZERO32; // R2
			ext_irq_polarity_reg <= 4'h0;
			gp_dir               <= 11'h000;     // R2 R6
			gp_out               <= 11'h000;
			pci_ctrl             <= 5'h00;
			irq_mask             <= 5'h00;
			irq_status           <= 5'h00;
		end else begin
			irq_status <= next_status;
			if (wr_en) begin
				if (i_paddr == `OFF_IRQ_ENABLE) begin
					core_irq_enable_reg <= i_pwdata; // R3
				end else if (i_paddr == `OFF_IRQ_POLARITY) begin
					ext_irq_polarity_reg <= i_pwdata[3:0]; // R5
				end else if (i_paddr == `OFF_GP_DIR) begin
					gp_dir <= i_pwdata[10:0];
				end else if (i_paddr == `OFF_GP_OUT) begin
					gp_out <= i_pwdata[10:0];
				end else if (i_paddr == `OFF_IRQ_MASK) begin
					irq_mask <= i_pwdata[4:0];
				end else if (i_paddr == `OFF_PCI_CTRL) begin
					pci_ctrl <= i_pwdata[4:0];
				end
			end
		end
	end

	// APB answer: zero wait states, data registered in the setup cycle
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata  <= `RST_ZERO32;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~mapped(i_paddr);
			o_prdata  <= `RST_ZERO32;
			if (i_psel && !i_penable && !i_pwrite) begin
				if (i_paddr == `OFF_IRQ_ENABLE) begin
					o_prdata <= core_irq_enable_reg;
				end else if (i_paddr == `OFF_IRQ_POLARITY) begin
					o_prdata <= {28'h000_0000, ext_irq_polarity_reg};
				end else if (i_paddr == `OFF_GP_DIR) begin
					o_prdata <= {21'h00_0000, gp_dir};
				end else if (i_paddr == `OFF_GP_OUT) begin
					o_prdata <= {21'h00_0000, gp_out};
				end else if (i_paddr == `OFF_GP_IN) begin
					o_prdata <= {21'h00_0000, i_gp_hi, ext_level};
				end else if (i_paddr == `OFF_IRQ_STATUS) begin
					o_prdata <= {27'h000_0000, next_status};
				end else if (i_paddr == `OFF_IRQ_MASK) begin
					o_prdata <= {27'h000_0000, irq_mask};
				end else if (i_paddr == `OFF_PCI_CTRL) begin
					o_prdata <= {27'h000_0000, o_pci_mode, pci_ctrl[3:0]};
				end
			end
		end
	end

	// Pin drive and core outputs, all registered
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ext_pin    <= 4'h0;
			o_ext_pin_oe <= 4'h0; // R2
			o_gp_hi      <= 7'h00;
			o_gp_hi_oe   <= 7'h00; // R6
			o_ext_irq    <= 4'h0;
			o_nmi_req    <= 1'b0;
			o_irq        <= 1'b0;
		end else begin
			o_ext_irq <= ext_edge & core_irq_enable_reg[`IER_EXT_MSB:`IER_EXT_LSB]; // R3
			o_nmi_req <= nmi_edge; // R1
			o_irq     <= |(irq_status & irq_mask);
			// Interrupt use forces the pin to input only
			o_ext_pin    <= gp_out[3:0];
			o_ext_pin_oe <= gp_dir[3:0] & ~core_irq_enable_reg[`IER_EXT_MSB:`IER_EXT_LSB]; // R3
			if (o_pci_mode) begin
				// Inputs never driven; outputs three-state under control
				o_gp_hi    <= 7'h00;
				o_gp_hi_oe <= 7'h00; // R7
				o_gp_hi[IDX_PCI_IRQA]    <= 1'b0;
				o_gp_hi_oe[IDX_PCI_IRQA] <= pci_ctrl[0]; // R7
				o_gp_hi[IDX_PCI_REQ]     <= 1'b0;
				o_gp_hi_oe[IDX_PCI_REQ]  <= pci_ctrl[1]; // R7
				o_gp_hi[IDX_PCI_BE3]     <= pci_ctrl[3];
				o_gp_hi_oe[IDX_PCI_BE3]  <= pci_ctrl[2]; // R7
			end else begin
				o_gp_hi    <= gp_out[10:4];
				o_gp_hi_oe <= gp_dir[10:4]; // R6 R8
			end
		end
	end
endmodule // gpio_ext_interrupt_pins

// File: testbench/pin_board_model.sv
// Purpose: Board side of the shared pins and of pins 15..9
// Assumes: Board drives pins 7..4 whenever the device does not
// Notes:   Undriven upper pins wander so stale values never look valid
`timescale 1ns/1ns
module pin_board_model (
	input  logic       i_ref_clk,  // Device clock
	input  logic [3:0] i_drv_ext,  // Board level on pins 7..4
	input  logic [3:0] i_dut_ext,  // Device level on pins 7..4
	input  logic [3:0] i_oe_ext,   // Device drives pins 7..4
	input  logic [6:0] i_dut_hi,   // Device level on pins 15..9
	input  logic [6:0] i_oe_hi,    // Device drives pins 15..9
	output logic [3:0] o_ext,      // Resolved pins 7..4
	output logic [6:0] o_hi        // Resolved pins 15..9
);
	logic [6:0] churn = 7'h2A;  // Floating level, flips each cycle
	// No pull on upper pins, so never let them settle
	always @(posedge i_ref_clk) begin
		churn <= ~churn;
	end
	// Device drive wins; board backs off where the device drives
	assign o_ext = (i_oe_ext & i_dut_ext) | (~i_oe_ext & i_drv_ext);
	assign o_hi = (i_oe_hi & i_dut_hi) | (~i_oe_hi & churn);
endmodule // pin_board_model

// File: testbench/gpio_pin_properties.sv
// Purpose: Port properties of the pin-function block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Pulse lag is three cycles: two sync flops and the output flop; the edge stage adds none
`timescale 1ns/1ns
module gpio_pin_properties #(
	parameter NUM_EXT = 4  // Shared interrupt pins
) (
	input logic       i_ref_clk,     // Device clock
	input logic       i_rst_n,       // Reset, active low
	input logic       i_nmi,         // Nmi pin
	input logic [3:0] i_ext_pin,     // Pins 7..4
	input logic [3:0] o_ext_pin_oe,  // Pins 7..4 enable
	input logic [6:0] o_gp_hi_oe,    // Pins 15..9 enable
	input logic       o_pci_mode,    // PCI selected
	input logic [3:0] o_ext_irq,     // Edge pulses
	input logic       o_nmi_req      // Nmi pulse
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Quiet pins for five samples
	sequence nmi_quiet; $stable(i_nmi) [*5]; endsequence
	sequence ext_quiet; $stable(i_ext_pin) [*5]; endsequence
	nmi_rise_a:
	assert property ($rose(i_nmi) |-> ##[2:4] o_nmi_req) else $error("nmi edge gave no request");
	nmi_level_a:
	assert property (nmi_quiet |-> !o_nmi_req) else $error("nmi request without edge");
	ext_level_a:
	assert property (ext_quiet |-> o_ext_irq == 4'h0) else $error("ext request without edge");
	ext_cause_a:
	assert property ((o_ext_irq & ~($past(i_ext_pin, 3) ^ $past(i_ext_pin, 4))) == 4'h0)
		else $error("ext request on unchanged pin");
	single_pulse_a:
	assert property ((o_nmi_req || o_ext_irq != 4'h0) |=> !o_nmi_req && (o_ext_irq & $past(o_ext_irq)) == 4'h0)
		else $error("request longer than one cycle");
	reset_idle_a:
	assert property ($rose(i_rst_n) |-> o_ext_pin_oe == 4'h0 && o_gp_hi_oe == 7'h00) else $error("pin driven after reset");
	strap_hold_a:
	assert property ($past(i_rst_n, 2) && $past(i_rst_n) |-> $stable(o_pci_mode)) else $error("mode moved after reset");
	pci_inputs_a:
	assert property (o_pci_mode |-> (o_gp_hi_oe & 7'h69) == 7'h00) else $error("PCI input pin driven");
endmodule // gpio_pin_properties
bind gpio_ext_interrupt_pins gpio_pin_properties #(.NUM_EXT(NUM_EXT)) gpio_pin_properties_i (.i_ref_clk, .i_rst_n,
	.i_nmi, .i_ext_pin, .o_ext_pin_oe, .o_gp_hi_oe, .o_pci_mode, .o_ext_irq, .o_nmi_req);

// File: testbench/gpio_ext_interrupt_pins_test.sv
// Purpose: Register-driven tests of pins, edges, nmi and PCI mode
// Assumes: APB slave answers with pready; board model on the pins
// Notes:   Second reset with the strap high covers PCI mode
`timescale 1ns/1ns
`include "gpio_irq_map.vh"
module gpio_ext_interrupt_pins_test;
	logic i_ref_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_nmi = 0, i_pci_en_strap = 0;
	logic [11:0] i_paddr = 12'h000;        // Bus address
	logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;  // Bus data
	logic o_pready, o_pslverr, err, o_pci_mode, o_nmi_req, o_irq;  // Status outputs
	logic [3:0] i_ext_pin, o_ext_pin, o_ext_pin_oe, o_ext_irq, seen, drv_ext = 4'h0;  // Shared pins
	logic [6:0] i_gp_hi, o_gp_hi, o_gp_hi_oe;  // Upper pins
	int bad_count = 0, checks_done = 0, pulses, cycles = 0;  // Tallies
	always #50 i_ref_clk = ~i_ref_clk;
	gpio_ext_interrupt_pins gpio_ext_interrupt_pins_i (.i_ref_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_nmi, .i_ext_pin, .o_ext_pin, .o_ext_pin_oe,
		.i_gp_hi, .o_gp_hi, .o_gp_hi_oe, .i_pci_en_strap, .o_pci_mode, .o_ext_irq, .o_nmi_req, .o_irq);
	pin_board_model pin_board_model_i (.i_ref_clk, .i_drv_ext(drv_ext), .i_dut_ext(o_ext_pin),
		.i_oe_ext(o_ext_pin_oe), .i_dut_hi(o_gp_hi), .i_oe_hi(o_gp_hi_oe), .o_ext(i_ext_pin), .o_hi(i_gp_hi));
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_ref_clk) {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'h2, w, a, d};
		@(posedge i_ref_clk) i_penable <= 1'h1;
		// No fixed wait count: only the hang guard ends a missing answer
		do @(posedge i_ref_clk); while (o_pready !== 1'h1);
		rd = o_prdata;
		err = o_pslverr;
		{i_psel, i_penable} <= 2'h0;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Gather request pulses over ten cycles
	task automatic watch;
		seen = 4'h0;
		pulses = 0;
		repeat (10) begin
			@(posedge i_ref_clk);
			seen = seen | o_ext_irq;
			pulses += (o_nmi_req === 1'h1) + (o_ext_irq != 4'h0);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard, run needs fewer than two hundred cycles
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop;
		end
	end
	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'h1;
		apb(0, `OFF_GP_DIR, 0);
		chk("dir", 0, rd);
		chk("ext oe", 0, o_ext_pin_oe);
		chk("hi oe", 0, o_gp_hi_oe);
		apb(0, 12'h020, 0);
		chk("slverr", 1, err);
		$display("test reset done");
		apb(1, `OFF_IRQ_MASK, 32'h0000_0010);
		@(posedge i_ref_clk) i_nmi <= 1'h1;
		watch;
		chk("nmi pulses", 1, pulses);
		chk("irq", 1, o_irq);
		watch;
		chk("nmi level", 0, pulses);
		apb(0, `OFF_IRQ_STATUS, 0);
		chk("status", 32'h0000_0010, rd);
		apb(0, `OFF_IRQ_STATUS, 0);
		chk("status clr", 0, rd);
		@(posedge i_ref_clk) i_nmi <= 1'h0;
		watch;
		chk("nmi fall", 0, pulses);
		$display("test nmi done");
		apb(1, `OFF_IRQ_ENABLE, 32'h0000_00F0);
		apb(1, `OFF_IRQ_POLARITY, 32'h0000_0005);
		@(posedge i_ref_clk) drv_ext <= 4'hF;
		watch;
		chk("rise", 4'h5, seen);
		@(posedge i_ref_clk) drv_ext <= 4'h0;
		watch;
		chk("fall", 4'hA, seen);
		apb(1, `OFF_IRQ_ENABLE, 0);
		@(posedge i_ref_clk) drv_ext <= 4'hF;
		watch;
		chk("disabled", 0, seen);
		$display("test edges done");
		apb(1, `OFF_GP_DIR, 32'h0000_07FF);
		apb(1, `OFF_GP_OUT, 32'h0000_0555);
		repeat (4) @(posedge i_ref_clk);
		chk("ext oe", 4'hF, o_ext_pin_oe);
		chk("ext out", 4'h5, o_ext_pin);
		chk("hi oe", 7'h7F, o_gp_hi_oe);
		chk("hi out", 7'h55, o_gp_hi);
		apb(0, `OFF_GP_IN, 0);
		chk("pin in", 4'h5, rd & 32'h0000_000F);
		$display("test drive done");
		@(posedge i_ref_clk) i_rst_n <= 1'h0;
		i_pci_en_strap <= 1'h1;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'h1;
		apb(0, `OFF_PCI_CTRL, 0);
		chk("strap", 1, rd[4]);
		chk("mode", 1, o_pci_mode);
		apb(1, `OFF_GP_DIR, 32'h0000_07FF);
		apb(1, `OFF_PCI_CTRL, 32'h0000_0007);
		repeat (2) @(posedge i_ref_clk);
		chk("pci oe", 7'h16, o_gp_hi_oe);
		chk("pci out", 0, o_gp_hi & 7'h16);
		$display("test pci done");
		report_and_stop;
	end
endmodule // gpio_ext_interrupt_pins_test
